// File: hw/tpo_pkg.sv
package tpo_pkg;
  // Timebase
  localparam int CLK_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CYC_HEAT = 8'h04;
  localparam logic [7:0] ADDR_CYC_COOL = 8'h08;
  localparam logic [7:0] ADDR_HOLD_HEAT = 8'h0c;
  localparam logic [7:0] ADDR_HOLD_COOL = 8'h10;
  localparam logic [7:0] ADDR_MV_HEAT = 8'h14;
  localparam logic [7:0] ADDR_MV_COOL = 8'h18;
  localparam logic [7:0] ADDR_OUTCFG0 = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam int N_OUT = 5;
  // Control register fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_ONOFF_BIT = 1;
  // Output configuration fields: four selectors, polarity, operation type
  localparam int SEL_W = 6;
  localparam int POL_LSB = 24;
  localparam int OP_LSB = 28;
  localparam int CFG_W = 31;
  localparam logic [CFG_W-1:0] OUTCFG_RST = 31'h0000_0000;
  // Operation types
  localparam logic [2:0] OP_DEFAULT = 3'h0;
  localparam logic [2:0] OP_HEAT = 3'h1;
  localparam logic [2:0] OP_COOL = 3'h2;
  localparam logic [2:0] OP_FN1 = 3'h3;
  localparam logic [2:0] OP_FN2 = 3'h4;
  localparam logic [2:0] OP_FN3 = 3'h5;
  localparam logic [2:0] OP_FN4 = 3'h6;
  // Source codes
  localparam int SRC_ON = 1;
  localparam int SRC_EVT1 = 2;
  localparam int SRC_HEAT = 14;
  localparam int SRC_COOL = 15;
  localparam int SRC_EVT_TERM = 48;
  localparam int SRC_CTRL_TERM = 49;
  // Cycle period in seconds
  localparam logic [6:0] CYC_MIN_S = 7'h01;
  localparam logic [6:0] CYC_MAX_S = 7'h78;
  localparam logic [6:0] CYC_RELAY_MIN_S = 7'h05;
  localparam logic [6:0] CYC_INIT_S = 7'h0a;
  localparam logic [6:0] CYC_VP_S = 7'h02;
  localparam logic [6:0] CYC_LONG_S = 7'h0a;
  localparam logic [16:0] MS_PER_S = 17'h003e8;
  // Minimum on/off time in ms
  localparam logic [7:0] HOLD_MAX_MS = 8'hfa;
  localparam logic [7:0] HOLD_SLOW_MS = 8'hfa;
  localparam logic [7:0] HOLD_FAST_MS = 8'h01;
  localparam logic [7:0] HOLD_RELAY_MS = 8'h32;
  localparam logic [7:0] HOLD_RST = 8'h00;
  // Manipulated variable in percent
  localparam logic [6:0] MV_FULL = 7'h64;
  localparam logic [6:0] MV_RST = 7'h00;
endpackage

// File: hw/tpo_pwm_chan.sv
`timescale 1ns/1ns
`default_nettype none
module tpo_pwm_chan
  import tpo_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ms_tick,
  input wire logic [16:0] period_ms,
  input wire logic [16:0] on_ms,
  input wire logic [7:0] min_hold,
  input wire logic single_mode,
  output logic wave_out
);
  logic [16:0] pos_ff, nxt_pos;
  logic [7:0] hold_ff, nxt_hold;
  logic wave_ff, nxt_wave;
  logic off_done_ff, nxt_off_done;
  logic wrap, want, hold_ok, do_switch;

  always_comb begin
    wrap = (pos_ff >= (period_ms - 17'h00001));
    want = (pos_ff < on_ms) && !(single_mode && off_done_ff);
    hold_ok = (hold_ff >= min_hold);
    do_switch = ms_tick && (want != wave_ff) && hold_ok;
    nxt_pos = pos_ff;
    if (ms_tick) begin
      nxt_pos = wrap ? 17'h00000 : pos_ff + 17'h00001;
    end
    nxt_wave = do_switch ? want : wave_ff;
    nxt_hold = hold_ff;
    if (do_switch) begin
      nxt_hold = 8'h01;
    end else if (ms_tick && hold_ff != 8'hff) begin
      nxt_hold = hold_ff + 8'h01;
    end
    nxt_off_done = off_done_ff;
    if (ms_tick && wrap) begin
      nxt_off_done = 1'b0;
    end else if (do_switch && !want) begin
      nxt_off_done = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pos_ff <= 17'h00000;
      hold_ff <= 8'hff;
      wave_ff <= 1'b0;
      off_done_ff <= 1'b0;
    end else begin
      pos_ff <= nxt_pos;
      hold_ff <= nxt_hold;
      wave_ff <= nxt_wave;
      off_done_ff <= nxt_off_done;
    end
  end

  assign wave_out = wave_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_HOLD_KEEPS: assert property (!(ms_tick && hold_ok) |=> $stable(wave_ff))
    else $error("Output switched before minimum hold elapsed");
  AST_HOLD_RESTART: assert property ($changed(wave_ff) |-> hold_ff == 8'h01)
    else $error("Hold timer not restarted on switch");
  AST_ONE_PULSE: assert property (single_mode && off_done_ff && !(ms_tick && wrap) |=> !$rose(wave_ff))
    else $error("Second on transition within one cycle");
  AST_ZERO_DUTY: assert property (ms_tick && on_ms == 17'h00000 && hold_ok |=> !wave_ff)
    else $error("Output on with zero duty");
  COV_RISE: cover property ($rose(wave_ff));
  COV_FALL: cover property ($fell(wave_ff));
endmodule // tpo_pwm_chan
`default_nettype wire

// File: hw/tpo_top.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Heat and cool cycle periods accepted from 1 to 120 s, 5 s floor with relay.
// - Cycle periods start at 2 s for voltage pulse outputs, 10 s otherwise.
// - Cycle mode 0 favours control, mode 1 allows one on/off per cycle.
// - The one cycle mode setting governs heat and cool alike.
// - Waveform routed by operation type to relay or event output uses at least a 5 s cycle; one picked as a source of types 3-6 does not.
// - After each switch the time-proportional heat and cool waveforms hold for the effective minimum on/off time.
// - Minimum setting 0 gives 250 ms for relay or cycle >= 10 s, else 1 ms.
// - When routed by operation type to relay or event output, settings 1-49 give 50 ms; 50-250 as set.
// - Heat carries on/off or time-proportional control; cool only cooling waveform.
// - Five outputs have an operation type: 1 heat waveform, 2 cool waveform.
// - Type 0: control outputs follow heat and cool, events follow internal events.
// - Types 3 to 6 give AND-OR, OR-AND, four-way OR, four-way AND of A-D.
// - Each output selects its four inputs A to D from a source list.
// - Each selected input is passed directly or inverted by its polarity bit.
module tpo_top
  import tpo_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ctrl_is_relay,
  input wire logic [1:0] ctrl_is_vpulse,
  input wire logic [4:0] int_event,
  input wire logic [63:0] misc_src,
  input wire logic onoff_demand,
  output logic [1:0] ctrl_out,
  output logic [2:0] evt_out
);
  function automatic logic [6:0] clamp_cyc(input logic [31:0] v);
    if (v < 32'(CYC_MIN_S)) begin
      return CYC_MIN_S;
    end else if (v > 32'(CYC_MAX_S)) begin
      return CYC_MAX_S;
    end
    return v[6:0];
  endfunction

  function automatic logic [7:0] eff_hold(input logic [7:0] set, input logic relay, input logic [6:0] cyc);
    if (set == 8'h00) begin
      return (relay || cyc >= CYC_LONG_S) ? HOLD_SLOW_MS : HOLD_FAST_MS;
    end else if (relay && set < HOLD_RELAY_MS) begin
      return HOLD_RELAY_MS;
    end
    return set;
  endfunction

  function automatic logic out_bit(input logic [2:0] op, input logic [3:0] p, input logic dflt,
                                   input logic heat, input logic cool);
    unique case (op)
      OP_DEFAULT: return dflt;
      OP_HEAT: return heat;
      OP_COOL: return cool;
      OP_FN1: return (p[0] & p[1]) | (p[2] & p[3]);
      OP_FN2: return (p[0] | p[1]) & (p[2] | p[3]);
      OP_FN3: return |p;
      OP_FN4: return &p;
      default: return 1'b0;
    endcase
  endfunction

  logic [15:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  logic init_done_ff, nxt_init_done;
  logic mode_ff, nxt_mode;
  logic onoff_ff, nxt_onoff;
  logic [6:0] cyc_heat_ff, nxt_cyc_heat, cyc_cool_ff, nxt_cyc_cool;
  logic [7:0] hold_heat_ff, nxt_hold_heat, hold_cool_ff, nxt_hold_cool;
  logic [6:0] mv_heat_ff, nxt_mv_heat, mv_cool_ff, nxt_mv_cool;
  logic [CFG_W-1:0] outcfg_ff [N_OUT];
  logic [CFG_W-1:0] nxt_outcfg [N_OUT];
  logic [1:0] ctrl_out_ff, nxt_ctrl_out;
  logic [2:0] evt_out_ff, nxt_evt_out;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic wr_en, setup;
  logic heat_relay, cool_relay;
  logic [6:0] heat_s, cool_s;
  logic [16:0] heat_period, cool_period, heat_on, cool_on;
  logic [7:0] heat_hold_eff, cool_hold_eff;
  logic heat_pwm, cool_pwm, heat_wave, cool_wave;
  logic [63:0] src_vec;
  logic [N_OUT-1:0] out_val, dflt;

  // Millisecond timebase
  always_comb begin
    nxt_tick = (tick_cnt_ff == 16'(TICK_LEN - 1));
    nxt_tick_cnt = nxt_tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // Register file over APB
  always_comb begin
    setup = psel && !penable;
    wr_en = psel && penable && pwrite && pready_ff;
    nxt_pready = setup;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_init_done = 1'b1;
    nxt_mode = mode_ff;
    nxt_onoff = onoff_ff;
    nxt_cyc_heat = cyc_heat_ff;
    nxt_cyc_cool = cyc_cool_ff;
    nxt_hold_heat = hold_heat_ff;
    nxt_hold_cool = hold_cool_ff;
    nxt_mv_heat = mv_heat_ff;
    nxt_mv_cool = mv_cool_ff;
    for (int i = 0; i < N_OUT; i++) begin
      nxt_outcfg[i] = outcfg_ff[i];
    end
    if (!init_done_ff) begin
      nxt_cyc_heat = ctrl_is_vpulse[0] ? CYC_VP_S : CYC_INIT_S;
      nxt_cyc_cool = ctrl_is_vpulse[1] ? CYC_VP_S : CYC_INIT_S;
    end
    if (setup) begin
      nxt_prdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_CTRL: nxt_prdata = 32'({onoff_ff, mode_ff});
        ADDR_CYC_HEAT: nxt_prdata = 32'(cyc_heat_ff);
        ADDR_CYC_COOL: nxt_prdata = 32'(cyc_cool_ff);
        ADDR_HOLD_HEAT: nxt_prdata = 32'(hold_heat_ff);
        ADDR_HOLD_COOL: nxt_prdata = 32'(hold_cool_ff);
        ADDR_MV_HEAT: nxt_prdata = 32'(mv_heat_ff);
        ADDR_MV_COOL: nxt_prdata = 32'(mv_cool_ff);
        ADDR_STATUS: nxt_prdata = 32'({cool_wave, heat_wave, evt_out_ff, ctrl_out_ff});
        default: begin
          nxt_pslverr = 1'b1;
          for (int i = 0; i < N_OUT; i++) begin
            if (paddr == ADDR_OUTCFG0 + 8'(4 * i)) begin
              nxt_prdata = 32'(outcfg_ff[i]);
              nxt_pslverr = 1'b0;
            end
          end
        end
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL: begin
          nxt_mode = pwdata[CTRL_MODE_BIT];
          nxt_onoff = pwdata[CTRL_ONOFF_BIT];
        end
        ADDR_CYC_HEAT: nxt_cyc_heat = clamp_cyc(pwdata);
        ADDR_CYC_COOL: nxt_cyc_cool = clamp_cyc(pwdata);
        ADDR_HOLD_HEAT: nxt_hold_heat = (pwdata > 32'(HOLD_MAX_MS)) ? HOLD_MAX_MS : pwdata[7:0];
        ADDR_HOLD_COOL: nxt_hold_cool = (pwdata > 32'(HOLD_MAX_MS)) ? HOLD_MAX_MS : pwdata[7:0];
        ADDR_MV_HEAT: nxt_mv_heat = (pwdata > 32'(MV_FULL)) ? MV_FULL : pwdata[6:0];
        ADDR_MV_COOL: nxt_mv_cool = (pwdata > 32'(MV_FULL)) ? MV_FULL : pwdata[6:0];
        default: begin
          for (int i = 0; i < N_OUT; i++) begin
            if (paddr == ADDR_OUTCFG0 + 8'(4 * i)) begin
              nxt_outcfg[i] = pwdata[CFG_W-1:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      init_done_ff <= 1'b0;
      mode_ff <= 1'b0;
      onoff_ff <= 1'b0;
      cyc_heat_ff <= CYC_INIT_S;
      cyc_cool_ff <= CYC_INIT_S;
      hold_heat_ff <= HOLD_RST;
      hold_cool_ff <= HOLD_RST;
      mv_heat_ff <= MV_RST;
      mv_cool_ff <= MV_RST;
      for (int i = 0; i < N_OUT; i++) begin
        outcfg_ff[i] <= OUTCFG_RST;
      end
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      init_done_ff <= nxt_init_done;
      mode_ff <= nxt_mode;
      onoff_ff <= nxt_onoff;
      cyc_heat_ff <= nxt_cyc_heat;
      cyc_cool_ff <= nxt_cyc_cool;
      hold_heat_ff <= nxt_hold_heat;
      hold_cool_ff <= nxt_hold_cool;
      mv_heat_ff <= nxt_mv_heat;
      mv_cool_ff <= nxt_mv_cool;
      for (int i = 0; i < N_OUT; i++) begin
        outcfg_ff[i] <= nxt_outcfg[i];
      end
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Routing to relay or event outputs and effective timing
  always_comb begin
    heat_relay = 1'b0;
    cool_relay = 1'b0;
    for (int i = 0; i < N_OUT; i++) begin
      if ((i >= 2) || ctrl_is_relay[i % 2]) begin
        if (outcfg_ff[i][OP_LSB+:3] == OP_HEAT || (i == 0 && outcfg_ff[i][OP_LSB+:3] == OP_DEFAULT)) begin
          heat_relay = 1'b1;
        end
        if (outcfg_ff[i][OP_LSB+:3] == OP_COOL || (i == 1 && outcfg_ff[i][OP_LSB+:3] == OP_DEFAULT)) begin
          cool_relay = 1'b1;
        end
      end
    end
    heat_s = (heat_relay && cyc_heat_ff < CYC_RELAY_MIN_S) ? CYC_RELAY_MIN_S : cyc_heat_ff;
    cool_s = (cool_relay && cyc_cool_ff < CYC_RELAY_MIN_S) ? CYC_RELAY_MIN_S : cyc_cool_ff;
    heat_period = 17'(heat_s * MS_PER_S);
    cool_period = 17'(cool_s * MS_PER_S);
    heat_on = 17'((24'(heat_period) * 24'(mv_heat_ff)) / 24'(MV_FULL));
    cool_on = 17'((24'(cool_period) * 24'(mv_cool_ff)) / 24'(MV_FULL));
    heat_hold_eff = eff_hold(hold_heat_ff, heat_relay, cyc_heat_ff);
    cool_hold_eff = eff_hold(hold_cool_ff, cool_relay, cyc_cool_ff);
  end

  tpo_pwm_chan u_heat (
    .clock(clock),
    .rstn(rstn),
    .ms_tick(tick_ff),
    .period_ms(heat_period),
    .on_ms(heat_on),
    .min_hold(heat_hold_eff),
    .single_mode(mode_ff),
    .wave_out(heat_pwm)
  );

  tpo_pwm_chan u_cool (
    .clock(clock),
    .rstn(rstn),
    .ms_tick(tick_ff),
    .period_ms(cool_period),
    .on_ms(cool_on),
    .min_hold(cool_hold_eff),
    .single_mode(mode_ff),
    .wave_out(cool_pwm)
  );

  // Output selection
  always_comb begin
    heat_wave = onoff_ff ? onoff_demand : heat_pwm;
    cool_wave = cool_pwm;
    src_vec = misc_src;
    src_vec[0] = 1'b0;
    src_vec[SRC_ON] = 1'b1;
    src_vec[SRC_EVT1+:5] = int_event;
    src_vec[SRC_HEAT] = heat_wave;
    src_vec[SRC_COOL] = cool_wave;
    src_vec[SRC_EVT_TERM] = evt_out_ff[0];
    src_vec[SRC_CTRL_TERM] = ctrl_out_ff[0];
    dflt = {int_event[2:0], cool_wave, heat_wave};
  end

  for (genvar gi = 0; gi < N_OUT; gi++) begin : g_out
    logic [3:0] pick;
    for (genvar gk = 0; gk < 4; gk++) begin : g_in
      assign pick[gk] = src_vec[outcfg_ff[gi][gk*SEL_W+:SEL_W]] ^ outcfg_ff[gi][POL_LSB+gk];
    end
    assign out_val[gi] = out_bit(outcfg_ff[gi][OP_LSB+:3], pick, dflt[gi], heat_wave, cool_wave);
  end

  always_comb begin
    nxt_ctrl_out = out_val[1:0];
    nxt_evt_out = out_val[4:2];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_out_ff <= 2'h0;
      evt_out_ff <= 3'h0;
    end else begin
      ctrl_out_ff <= nxt_ctrl_out;
      evt_out_ff <= nxt_evt_out;
    end
  end

  assign ctrl_out = ctrl_out_ff;
  assign evt_out = evt_out_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_CYC_RANGE: assert property (cyc_heat_ff >= CYC_MIN_S && cyc_heat_ff <= CYC_MAX_S && cyc_cool_ff >= CYC_MIN_S && cyc_cool_ff <= CYC_MAX_S)
    else $error("Cycle period out of range");
  AST_INIT_VP: assert property (!init_done_ff && ctrl_is_vpulse[0] |=> cyc_heat_ff == CYC_VP_S)
    else $error("Heat cycle not initialised to voltage pulse value");
  AST_RELAY_FLOOR: assert property (heat_relay |-> heat_s >= CYC_RELAY_MIN_S && heat_period >= 17'h01388)
    else $error("Relay cycle below floor");
  AST_HOLD_ZERO: assert property (hold_heat_ff == 8'h00 && (heat_relay || cyc_heat_ff >= CYC_LONG_S) |-> heat_hold_eff == 8'hfa)
    else $error("Default minimum time wrong");
  AST_HOLD_FLOOR: assert property (heat_relay && hold_heat_ff != 8'h00 && hold_heat_ff < 8'h32 |-> heat_hold_eff == 8'h32)
    else $error("Relay minimum time floor wrong");
  AST_HOLD_DIRECT: assert property (!cool_relay && hold_cool_ff != 8'h00 |-> cool_hold_eff == hold_cool_ff)
    else $error("Direct minimum time wrong");
  AST_ONOFF_HEAT: assert property (onoff_ff && outcfg_ff[0][OP_LSB+:3] == OP_HEAT |=> ctrl_out_ff[0] == $past(onoff_demand))
    else $error("On/off demand not on heat output");
  AST_OP_HEAT: assert property (outcfg_ff[1][OP_LSB+:3] == OP_HEAT |=> ctrl_out_ff[1] == $past(heat_wave))
    else $error("Control output 2 not following heat waveform");
  AST_DEF_EVT: assert property (outcfg_ff[3][OP_LSB+:3] == OP_DEFAULT |=> evt_out_ff[1] == $past(int_event[1]))
    else $error("Event output 2 not following internal event 2");
  AST_FN_OR: assert property (outcfg_ff[2][OP_LSB+:3] == OP_FN3 |=> evt_out_ff[0] == $past(|g_out[2].pick))
    else $error("Four-way OR wrong");
  AST_FN_ANDOR: assert property (outcfg_ff[0][OP_LSB+:3] == OP_FN1 && g_out[0].pick == 4'h3 |=> ctrl_out_ff[0])
    else $error("AND-OR function wrong");
  AST_APB_ONE: assert property (psel && penable && pready_ff |=> !pready_ff)
    else $error("Ready held past access");
  COV_HEAT_RISE: cover property ($rose(heat_wave));
  COV_FN_ON: cover property (outcfg_ff[4][OP_LSB+:3] == OP_FN2 ##1 evt_out_ff[2]);
  COV_CYC_WRITE: cover property (wr_en && paddr == ADDR_CYC_HEAT);
endmodule // tpo_top
`default_nettype wire

// File: test/tpo_relay_model.sv
`timescale 1ns/1ns
`default_nettype none
// Relay or pulse driver: measures on-run and rise-to-rise spacing in clocks
module tpo_relay_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic drive,
  output int on_len,
  output int period
);
  int run_ff;
  int gap_ff;
  logic prev_ff;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_ff <= 0;
      gap_ff <= 0;
      prev_ff <= 1'b0;
      on_len <= 0;
      period <= 0;
    end else begin
      prev_ff <= drive;
      if (drive) begin
        run_ff <= run_ff + 1;
      end
      if (prev_ff && !drive) begin
        on_len <= run_ff;
      end
      if (drive && !prev_ff) begin
        period <= gap_ff;
        gap_ff <= 1;
        run_ff <= 1;
      end else begin
        gap_ff <= gap_ff + 1;
      end
    end
  end
endmodule // tpo_relay_model
`default_nettype wire

// File: test/tpo_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tpo_top_tb;
  import tpo_pkg::*;
  localparam int MSC = 4;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ctrl_is_relay = 2'h0;
  logic [1:0] ctrl_is_vpulse = 2'h1;
  logic [4:0] int_event = 5'h00;
  logic [63:0] misc_src = 64'h0;
  logic onoff_demand = 1'b0;
  logic [1:0] ctrl_out;
  logic [2:0] evt_out;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int on0, per0, on1, per1;
  logic [31:0] seed = 32'h1a;
  always #25 clock = ~clock;
  tpo_top #(.TICK_LEN(MSC)) tpo_top_inst (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_is_relay(ctrl_is_relay), .ctrl_is_vpulse(ctrl_is_vpulse), .int_event(int_event),
    .misc_src(misc_src), .onoff_demand(onoff_demand), .ctrl_out(ctrl_out), .evt_out(evt_out));
  tpo_relay_model tpo_relay_model_inst (.clock(clock), .rstn(rstn), .drive(ctrl_out[0]), .on_len(on0),
    .period(per0));
  tpo_relay_model tpo_relay_model_cool_inst (.clock(clock), .rstn(rstn), .drive(ctrl_out[1]), .on_len(on1),
    .period(per1));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic exp_fn(logic [2:0] op, logic [3:0] v, logic ev);
    case (op)
      OP_DEFAULT: return ev;
      OP_FN1: return (v[0] & v[1]) | (v[2] & v[3]);
      OP_FN2: return (v[0] | v[1]) & (v[2] | v[3]);
      OP_FN3: return |v;
      OP_FN4: return &v;
      default: return 1'b0;
    endcase
  endfunction
  task stop_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
    int w;
    w = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && w < 20) begin
      @(posedge clock);
      w++;
    end
    if (w == 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  task near(input int got, input int ms);
    `CHK((got >= (ms - 1) * MSC && got <= (ms + 1) * MSC), 1'b1)
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 85000) begin
      fails++;
      stop_test();
    end
  end
  logic [7:0] ca [4] = '{ADDR_CYC_HEAT, ADDR_CYC_HEAT, ADDR_HOLD_COOL, ADDR_MV_HEAT};
  logic [31:0] cw [4] = '{32'h0, 32'hc8, 32'h1ff, 32'hff};
  logic [31:0] ce [4] = '{32'h1, 32'h78, 32'hfa, 32'h64};
  logic [2:0] ops [6] = '{OP_FN1, OP_FN2, OP_FN3, OP_FN4, OP_DEFAULT, 3'h7};
  int mvh [2] = '{30, 5};
  int hh [2] = '{0, 100};
  int eh [2] = '{300, 100};
  int mvc [2] = '{60, 95};
  int hc [2] = '{0, 20};
  int ec [2] = '{600, 950};
  logic [5:0] sel [3][4];
  logic [3:0] pol [3];
  logic [3:0] v;
  logic [31:0] r;
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd_chk(ADDR_CYC_HEAT, 32'h2, 1'b0);
    rd_chk(ADDR_CYC_COOL, 32'ha, 1'b0);
    rd_chk(ADDR_HOLD_COOL, 32'h0, 1'b0);
    rd_chk(ADDR_OUTCFG0, 32'h0, 1'b0);
    rd_chk(8'h34, 32'h0, 1'b1);
    wr(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_CTRL, 32'h1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ca[i], cw[i]);
      rd_chk(ca[i], ce[i], 1'b0);
    end
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_OUTCFG0, 32'h1000_0000);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      onoff_demand <= r[0];
      repeat (1100) @(posedge clock);
      `CHK(ctrl_out[0], onoff_demand)
    end
    wr(ADDR_CTRL, 32'h0);
    for (int k = 0; k < 12; k++) begin
      for (int j = 0; j < 3; j++) begin
        for (int m = 0; m < 4; m++) sel[j][m] = 6'(18 + xs() % 30);
        r = xs();
        pol[j] = r[3:0];
        wr(8'(ADDR_OUTCFG0 + 4 * (j + 2)), {1'b0, ops[k % 6], pol[j], sel[j][3], sel[j][2], sel[j][1], sel[j][0]});
      end
      misc_src <= {xs(), xs()};
      r = xs();
      int_event <= r[4:0];
      repeat (3) @(posedge clock);
      for (int j = 0; j < 3; j++) begin
        for (int m = 0; m < 4; m++) v[m] = misc_src[sel[j][m]] ^ pol[j][m];
        `CHK(evt_out[j], exp_fn(ops[k % 6], v, int_event[j]))
      end
    end
    wr(ADDR_CYC_HEAT, 32'h1);
    wr(ADDR_CYC_COOL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_MV_HEAT, mvh[i]);
      wr(ADDR_HOLD_HEAT, hh[i]);
      wr(ADDR_MV_COOL, mvc[i]);
      wr(ADDR_HOLD_COOL, hc[i]);
      repeat (12000) @(posedge clock);
      near(on0, eh[i]);
      `CHK(per0, 1000 * MSC)
      near(on1, ec[i]);
      `CHK(per1, 1000 * MSC)
    end
    wr(ADDR_OUTCFG0 + 8'h08, 32'h1000_0000);
    wr(ADDR_MV_HEAT, 32'h2);
    wr(ADDR_HOLD_HEAT, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    repeat (46000) @(posedge clock);
    near(on0, 250);
    `CHK(per0, 5000 * MSC)
    `CHK(evt_out[0], ctrl_out[0])
    stop_test();
  end
endmodule // tpo_top_tb
`default_nettype wire
